// >>> design/ptc_pattern_control.sv
// Summary of operation
// - Pattern mode one sends plus one, minus one, repeating forever.
// - Pattern mode two sends ten plus ones then ten minus ones, repeating.
// - Pattern mode three transmits as normal master data carrying only interframe idle.
// - Transmit-silence mode keeps paths running but forces every symbol to zero.
// - Pattern modes change only the symbols fed to the transmitter.
// - Selection field bits 15..13: codes 001, 010, 011 pick modes one to three.
// - Device flags power-down entry ready; host waits for it before configuring.
// - Setting transmit-silence enable during the power-down window selects silence mode if forced mode is on and autonegotiation off.
// - Clearing the power-down request exits power-down; the selected pattern starts only with forced mode on and autonegotiation off, else normal mode.
// - With far-end loopback on and the generator or diagnostic clock off, frames received on the line go back out.
// - Originating device sends generated frames and checks the looped-back frames.
// - Loopback with receive-suppress set keeps line data off the MAC side.
// - Enabled generator with diagnostic clock overrides MAC transmit data on the line.
`timescale 1ns/100ps
`default_nettype none
`include "ptc_consts.svh"

module ptc_pattern_control #(
	parameter logic [7:0] SYM_DIV = 8'h01,
	parameter logic [15:0] FG_LEN = 16'h0040,
	parameter logic [15:0] FG_FRAMES = 16'h0010
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic soft_powerdown_request_i,
	input wire logic autoneg_enable_i,
	input wire logic autoneg_forced_mode_i,
	input wire logic [15:0] tx_pattern_control_i,
	input wire logic tx_silence_enable_i,
	input wire logic far_end_loopback_enable_i,
	input wire logic far_end_loopback_rx_suppress_i,
	input wire logic diagnostic_clock_enable_i,
	input wire logic frame_gen_enable_i,
	input wire logic frame_check_enable_i,
	input wire logic [1:0] norm_sym_i,
	input wire logic [1:0] idle_sym_i,
	input wire logic [7:0] mac_txd_i,
	input wire logic mac_tx_en_i,
	input wire logic [7:0] line_rxd_i,
	input wire logic line_rx_dv_i,
	output logic soft_powerdown_ready_o,
	output logic [1:0] tx_sym_o,
	output logic [7:0] line_txd_o,
	output logic line_tx_en_o,
	output logic [7:0] mac_rxd_o,
	output logic mac_rx_dv_o,
	output logic frame_gen_done_o,
	output logic [15:0] check_frames_o,
	output logic [15:0] check_errors_o
);

	// --------------------------------------------------------------------------
	// Constants and decoding
	// --------------------------------------------------------------------------
	localparam int PD_CYC = (`PTC_PD_ENTRY_NS + `PTC_CLK_PERIOD_NS - 1) / `PTC_CLK_PERIOD_NS;

	// Maps the selection field and silence bit to a symbol source.
	function automatic ptc_pkg::ptc_mode_type mode_decode(input logic [2:0] sel, input logic silence);
		ptc_pkg::ptc_mode_type m;
		m = ptc_pkg::PTC_NORMAL;
		if (silence) begin
			m = ptc_pkg::PTC_SILENT;
		end else begin
			unique case (sel)
				`PTC_SEL_ALT: m = ptc_pkg::PTC_ALT;
				`PTC_SEL_DROOP: m = ptc_pkg::PTC_DROOP;
				`PTC_SEL_IDLE: m = ptc_pkg::PTC_IDLE;
				default: m = ptc_pkg::PTC_NORMAL;
			endcase
		end
		return m;
	endfunction

	ptc_pkg::ptc_state_type st_q;
	ptc_pkg::ptc_state_type st_d;
	logic sym_en;
	logic gen_sel;

	// Symbol slot pulse from the divider; the generator owns the line only with its clock enabled.
	assign sym_en = (st_q.div == 8'h00);
	assign gen_sel = frame_gen_enable_i && diagnostic_clock_enable_i;

	// --------------------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------------------
	// A single process builds the next state so that priorities stay readable in one place.
	always_comb begin
		st_d = st_q;
		// Symbol slot divider.
		if (st_q.div >= SYM_DIV - 8'h01) begin
			st_d.div = 8'h00;
		end else begin
			st_d.div = st_q.div + 8'h01;
		end

		// Power-down handshake; the mode is only taken on exit so a half-written setup never leaks out.
		unique case (st_q.pd)
			ptc_pkg::PTC_PD_RUN: begin
				if (soft_powerdown_request_i) begin
					st_d.pd = ptc_pkg::PTC_PD_ENTER;
					st_d.pd_cnt = 3'(PD_CYC);
				end
			end
			ptc_pkg::PTC_PD_ENTER: begin
				if (!soft_powerdown_request_i) begin
					st_d.pd = ptc_pkg::PTC_PD_RUN;
				end else if (st_q.pd_cnt <= 3'h1) begin
					st_d.pd = ptc_pkg::PTC_PD_DOWN;
					st_d.ready = 1'b1;
				end else begin
					st_d.pd_cnt = st_q.pd_cnt - 3'h1;
				end
			end
			ptc_pkg::PTC_PD_DOWN: begin
				if (!soft_powerdown_request_i) begin
					st_d.pd = ptc_pkg::PTC_PD_RUN;
					st_d.ready = 1'b0;
					st_d.alt = 1'b0;
					st_d.droop = 5'h00;
					// Test sources need forced mode with autonegotiation off; otherwise stay normal.
					if (autoneg_forced_mode_i && !autoneg_enable_i) begin
						st_d.mode = mode_decode(tx_pattern_control_i[`PTC_SEL_MSB:`PTC_SEL_LSB],
							tx_silence_enable_i);
					end else begin
						st_d.mode = ptc_pkg::PTC_NORMAL;
					end
				end
			end
		endcase

		// Symbol source; only the symbol value changes, framing paths run untouched.
		if (st_q.pd != ptc_pkg::PTC_PD_RUN) begin
			st_d.sym = `PTC_SYM_ZERO;
		end else if (sym_en) begin
			unique case (st_q.mode)
				ptc_pkg::PTC_ALT: begin
					st_d.sym = st_q.alt ? `PTC_SYM_NEG : `PTC_SYM_POS;
					st_d.alt = !st_q.alt;
				end
				ptc_pkg::PTC_DROOP: begin
					st_d.sym = (st_q.droop < `PTC_DROOP_HALF) ? `PTC_SYM_POS : `PTC_SYM_NEG;
					st_d.droop = (st_q.droop == `PTC_DROOP_LAST) ? 5'h00 : st_q.droop + 5'h01;
				end
				ptc_pkg::PTC_IDLE: st_d.sym = idle_sym_i;
				ptc_pkg::PTC_SILENT: st_d.sym = `PTC_SYM_ZERO;
				ptc_pkg::PTC_NORMAL: st_d.sym = norm_sym_i;
			endcase
		end

		// Frame generator: starts on the rising edge of its enable, ends after the frame count.
		st_d.gen_prev = gen_sel;
		if (!gen_sel) begin
			st_d.gen_on = 1'b0;
		end else if (!st_q.gen_prev) begin
			st_d.gen_on = 1'b1;
			st_d.gen_idx = 16'h0000;
			st_d.gen_frm = 16'h0000;
			st_d.gen_gap = 4'h0;
			st_d.gen_done = 1'b0;
		end else if (st_q.gen_on) begin
			if (st_q.gen_gap != 4'h0) begin
				st_d.gen_gap = st_q.gen_gap - 4'h1;
			end else if (st_q.gen_idx == FG_LEN - 16'h0001) begin
				st_d.gen_idx = 16'h0000;
				st_d.gen_gap = `PTC_GEN_GAP;
				st_d.gen_frm = st_q.gen_frm + 16'h0001;
				if (st_q.gen_frm == FG_FRAMES - 16'h0001) begin
					st_d.gen_on = 1'b0;
					st_d.gen_done = 1'b1;
				end
			end else begin
				st_d.gen_idx = st_q.gen_idx + 16'h0001;
			end
		end

		// Line transmit source: generator, then far-end echo, then MAC.
		if (gen_sel) begin
			st_d.ltxen = st_q.gen_on && (st_q.gen_gap == 4'h0);
			st_d.ltxd = st_q.gen_idx[7:0];
		end else if (far_end_loopback_enable_i) begin
			st_d.ltxen = line_rx_dv_i;
			st_d.ltxd = line_rxd_i;
		end else begin
			st_d.ltxen = mac_tx_en_i;
			st_d.ltxd = mac_txd_i;
		end

		// MAC receive side is silenced while the echo runs with suppression.
		if (far_end_loopback_enable_i && far_end_loopback_rx_suppress_i) begin
			st_d.mrxdv = 1'b0;
			st_d.mrxd = 8'h00;
		end else begin
			st_d.mrxdv = line_rx_dv_i;
			st_d.mrxd = line_rxd_i;
		end

		// Frame checker expects the generator's counting payload and a frame of full length.
		if (frame_check_enable_i) begin
			if (line_rx_dv_i) begin
				if (!st_q.chk_in) begin
					st_d.chk_in = 1'b1;
					st_d.chk_idx = 16'h0001;
					st_d.chk_bad = (line_rxd_i != 8'h00);
				end else begin
					st_d.chk_idx = st_q.chk_idx + 16'h0001;
					if (line_rxd_i != st_q.chk_idx[7:0]) begin
						st_d.chk_bad = 1'b1;
					end
				end
			end else if (st_q.chk_in) begin
				st_d.chk_in = 1'b0;
				st_d.chk_frm = st_q.chk_frm + 16'h0001;
				if (st_q.chk_bad || st_q.chk_idx != FG_LEN) begin
					st_d.chk_err = st_q.chk_err + 16'h0001;
				end
			end
		end else begin
			st_d.chk_in = 1'b0;
		end
	end

	// --------------------------------------------------------------------------
	// State register
	// --------------------------------------------------------------------------
	// Reset leaves the transmitter in normal mode with a zero symbol and both paths idle.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign soft_powerdown_ready_o = st_q.ready;
	assign tx_sym_o = st_q.sym;
	assign line_txd_o = st_q.ltxd;
	assign line_tx_en_o = st_q.ltxen;
	assign mac_rxd_o = st_q.mrxd;
	assign mac_rx_dv_o = st_q.mrxdv;
	assign frame_gen_done_o = st_q.gen_done;
	assign check_frames_o = st_q.chk_frm;
	assign check_errors_o = st_q.chk_err;

	// --------------------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence run_slot(ptc_pkg::ptc_mode_type m);
		st_q.pd == ptc_pkg::PTC_PD_RUN && st_q.mode == m && sym_en;
	endsequence

	sequence frame_end;
		frame_check_enable_i && st_q.chk_in && !line_rx_dv_i;
	endsequence

	chk_alt_toggles: assert property (run_slot(ptc_pkg::PTC_ALT) |=> st_q.sym != $past(st_q.sym))
		else $error("alternating pattern did not change symbol");
	chk_droop_start: assert property (run_slot(ptc_pkg::PTC_DROOP) and st_q.droop == 5'h00
		|=> st_q.sym == `PTC_SYM_POS)
		else $error("droop block did not open positive");
	chk_droop_turn: assert property (run_slot(ptc_pkg::PTC_DROOP) and st_q.droop == `PTC_DROOP_HALF
		|=> st_q.sym == `PTC_SYM_NEG)
		else $error("droop block did not turn negative after ten");
	chk_silent_zero: assert property (run_slot(ptc_pkg::PTC_SILENT) |=> st_q.sym == `PTC_SYM_ZERO)
		else $error("silence mode sent a nonzero symbol");
	chk_normal_pass: assert property (run_slot(ptc_pkg::PTC_NORMAL) |=> st_q.sym == $past(norm_sym_i))
		else $error("normal mode did not pass the data symbol");
	chk_pd_ready: assert property ($rose(st_q.ready) |-> st_q.pd == ptc_pkg::PTC_PD_DOWN
		&& $past(st_q.pd) == ptc_pkg::PTC_PD_ENTER)
		else $error("ready flag rose outside power-down entry");
	chk_pd_quiet: assert property (st_q.pd != ptc_pkg::PTC_PD_RUN |=> st_q.sym == `PTC_SYM_ZERO)
		else $error("symbol sent during power-down");
	chk_gen_owns: assert property (gen_sel |=> st_q.ltxen == $past(st_q.gen_on && st_q.gen_gap == 4'h0))
		else $error("generator did not own the line");
	chk_loop_echo: assert property (far_end_loopback_enable_i && !gen_sel
		|=> st_q.ltxen == $past(line_rx_dv_i) && st_q.ltxd == $past(line_rxd_i))
		else $error("far-end loopback did not echo the line");
	chk_rx_suppress: assert property (far_end_loopback_enable_i && far_end_loopback_rx_suppress_i
		|=> !st_q.mrxdv)
		else $error("suppressed loopback data reached the MAC side");
	chk_frame_count: assert property (frame_end |=> st_q.chk_frm == $past(st_q.chk_frm) + 16'h0001)
		else $error("checker missed a frame end");

endmodule // ptc_pattern_control

`default_nettype wire

// >>> design/ptc_consts.svh
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Pattern selection field of the pattern control word
// ----------------------------------------------------------------------------
`define PTC_SEL_MSB 15
`define PTC_SEL_LSB 13
`define PTC_SEL_NORMAL 3'h0
`define PTC_SEL_ALT 3'h1
`define PTC_SEL_DROOP 3'h2
`define PTC_SEL_IDLE 3'h3
`define PTC_CTRL_RESET 16'h0000

// ----------------------------------------------------------------------------
// Line symbol codes, two's complement: +1, -1 and 0
// ----------------------------------------------------------------------------
`define PTC_SYM_POS 2'h1
`define PTC_SYM_NEG 2'h3
`define PTC_SYM_ZERO 2'h0

// ----------------------------------------------------------------------------
// Droop block: ten positive then ten negative symbols
// ----------------------------------------------------------------------------
`define PTC_DROOP_HALF 5'h0a
`define PTC_DROOP_LAST 5'h13

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PTC_CLK_PERIOD_NS 100
`define PTC_PD_ENTRY_NS 400
`define PTC_GEN_GAP 4'hc

`endif

// >>> design/ptc_pkg.sv
package ptc_pkg;

	// Power-down handshake states.
	typedef enum logic [1:0] {PTC_PD_RUN, PTC_PD_ENTER, PTC_PD_DOWN} ptc_pd_type;

	// Transmit symbol source selected at power-down exit.
	typedef enum logic [2:0] {PTC_NORMAL, PTC_ALT, PTC_DROOP, PTC_IDLE, PTC_SILENT} ptc_mode_type;

	// Whole state of the pattern control block.
	typedef struct packed {
		ptc_pd_type pd;
		logic [2:0] pd_cnt;
		logic ready;
		ptc_mode_type mode;
		logic alt;
		logic [4:0] droop;
		logic [7:0] div;
		logic [1:0] sym;
		logic [7:0] ltxd;
		logic ltxen;
		logic [7:0] mrxd;
		logic mrxdv;
		logic gen_prev;
		logic gen_on;
		logic [15:0] gen_idx;
		logic [15:0] gen_frm;
		logic [3:0] gen_gap;
		logic gen_done;
		logic chk_in;
		logic chk_bad;
		logic [15:0] chk_idx;
		logic [15:0] chk_frm;
		logic [15:0] chk_err;
	} ptc_state_type;

endpackage

// >>> tb/ptc_remote_phy.sv
`timescale 1ns/100ps
`default_nettype none

// Far-end PHY with remote loopback on: every line byte comes back one edge later.
module ptc_remote_phy (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] line_txd_i,
	input wire logic line_tx_en_i,
	input wire logic corrupt_i,
	output logic [7:0] line_rxd_o,
	output logic line_rx_dv_o
);
	// Outside frames the data lines toggle, so stale bytes never look valid.
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			line_rxd_o <= 8'h00;
			line_rx_dv_o <= 1'b0;
		end else if (line_tx_en_i) begin
			line_rxd_o <= line_txd_i ^ {7'h00, corrupt_i};
			line_rx_dv_o <= 1'b1;
		end else begin
			line_rxd_o <= ~line_rxd_o;
			line_rx_dv_o <= 1'b0;
		end
	end
endmodule // ptc_remote_phy

`default_nettype wire

// >>> tb/ptc_pattern_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`include "ptc_consts.svh"

module ptc_pattern_control_tb_top;
	logic sys_clk = 1'b0, rst_b = 1'b0, req = 1'b0, an = 1'b1, forced = 1'b0, sil = 1'b0;
	logic lb = 1'b0, sup = 1'b0, diag = 1'b0, gen = 1'b0, chk = 1'b1, bad = 1'b0, tx_en = 1'b0;
	logic [15:0] ctrl = 16'h0000;
	logic [7:0] rxd, txd, mrxd;
	logic rx_dv, txv, ready, mdv, done, mdv_seen;
	logic [1:0] sym, norm = 2'h3;
	logic [15:0] frames, errs;
	int error_cnt = 0, checks_done = 0;

	always #50 sys_clk = ~sys_clk;

	// The normal symbol source changes every edge, so a stuck symbol cannot pass for pass-through.
	always @(posedge sys_clk) norm <= ~norm;

	ptc_pattern_control #(.FG_LEN(16'h0004), .FG_FRAMES(16'h0002)) i_ptc_pattern_control (
		.sys_clk_i(sys_clk), .rst_b_i(rst_b), .soft_powerdown_request_i(req),
		.autoneg_enable_i(an), .autoneg_forced_mode_i(forced), .tx_pattern_control_i(ctrl),
		.tx_silence_enable_i(sil), .far_end_loopback_enable_i(lb), .far_end_loopback_rx_suppress_i(sup),
		.diagnostic_clock_enable_i(diag), .frame_gen_enable_i(gen), .frame_check_enable_i(chk),
		.norm_sym_i(norm), .idle_sym_i(2'h1), .mac_txd_i(8'ha5), .mac_tx_en_i(tx_en),
		.line_rxd_i(rxd), .line_rx_dv_i(rx_dv), .soft_powerdown_ready_o(ready), .tx_sym_o(sym),
		.line_txd_o(txd), .line_tx_en_o(txv), .mac_rxd_o(mrxd), .mac_rx_dv_o(mdv),
		.frame_gen_done_o(done), .check_frames_o(frames), .check_errors_o(errs));

	ptc_remote_phy i_ptc_remote_phy (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .line_txd_i(txd),
		.line_tx_en_i(txv), .corrupt_i(bad), .line_rxd_o(rxd), .line_rx_dv_o(rx_dv));

	// ----------------------------------------------------------------------
	// Comparison and closing
	// ----------------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// A wait that runs out is a hang; it is counted and the run is closed.
	task automatic timed_out();
		error_cnt++;
		$display("mismatch at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
		close_out();
	endtask

	// Expected symbol i slots after the first pattern symbol, per latched mode.
	function automatic logic [1:0] exp_sym(input int m, input int i);
		case (m)
			1: exp_sym = (i % 2 == 0) ? 2'h1 : 2'h3;
			2: exp_sym = (i % 20 < 10) ? 2'h1 : 2'h3;
			3: exp_sym = 2'h1;
			4: exp_sym = 2'h0;
			default: exp_sym = 2'h3;
		endcase
	endfunction

	// ----------------------------------------------------------------------
	// Power-down configuration sequence, then symbol stream check
	// ----------------------------------------------------------------------
	task automatic run_mode(input logic [2:0] code, input logic s, input logic a, input logic f, input int m);
		int k;
		logic [1:0] e;
		@(posedge sys_clk);
		req <= 1'b1;
		for (k = 1; k <= 20 && ready !== 1'b1; k++) begin
			@(posedge sys_clk);
			#1;
		end
		if (ready !== 1'b1)
			timed_out();
		check(16'(k - 1), 16'(`PTC_PD_ENTRY_NS / `PTC_CLK_PERIOD_NS + 1));
		check(sym, 2'h0);
		@(posedge sys_clk);
		an <= a;
		@(posedge sys_clk);
		forced <= f;
		@(posedge sys_clk);
		ctrl <= {code, 13'h0000};
		sil <= s;
		@(posedge sys_clk);
		req <= 1'b0;
		for (k = 0; k < 20 && ready !== 1'b0; k++) begin
			@(posedge sys_clk);
			#1;
		end
		if (ready !== 1'b0)
			timed_out();
		for (k = 0; k < 40; k++) begin
			@(posedge sys_clk);
			#1;
			e = (m == 0) ? ~norm : exp_sym(m, k);
			check(sym, e);
		end
		@(posedge sys_clk);
		sil <= 1'b0;
		an <= 1'b1;
		forced <= 1'b0;
	endtask

	// ----------------------------------------------------------------------
	// Generator run through the far-end loopback into the local checker
	// ----------------------------------------------------------------------
	task automatic run_gen(input logic l, input logic sp, input logic c, input logic [15:0] f,
			input logic [15:0] e, input logic mac_exp);
		int k;
		logic [7:0] mb;
		@(posedge sys_clk);
		lb <= l;
		sup <= sp;
		bad <= c;
		diag <= 1'b1;
		gen <= 1'b1;
		tx_en <= 1'b1;
		mdv_seen = 1'b0;
		mb = 8'h00;
		for (k = 0; k < 2000 && frames !== f; k++) begin
			@(posedge sys_clk);
			#1;
			if (mdv === 1'b1) begin
				mdv_seen = 1'b1;
				check(mrxd, mb ^ {7'h00, c});
				mb = mb + 8'h01;
			end else begin
				mb = 8'h00;
				if (sp)
					check(mrxd, 8'h00);
			end
		end
		if (frames !== f)
			timed_out();
		check(done, 1'b1);
		check(frames, f);
		check(errs, e);
		check(mdv_seen, mac_exp);
		@(posedge sys_clk);
		gen <= 1'b0;
		tx_en <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge sys_clk);
		run_mode(3'h1, 1'b0, 1'b0, 1'b1, 1);
		run_mode(3'h2, 1'b0, 1'b0, 1'b1, 2);
		run_mode(3'h3, 1'b0, 1'b0, 1'b1, 3);
		run_mode(3'h2, 1'b1, 1'b0, 1'b1, 4);
		run_mode(3'h0, 1'b0, 1'b0, 1'b1, 0);
		run_mode(3'h1, 1'b0, 1'b1, 1'b1, 0);
		run_mode(3'h1, 1'b0, 1'b0, 1'b0, 0);
		run_gen(1'b0, 1'b0, 1'b0, 16'h0002, 16'h0000, 1'b1);
		run_gen(1'b1, 1'b1, 1'b0, 16'h0004, 16'h0000, 1'b0);
		run_gen(1'b0, 1'b0, 1'b1, 16'h0006, 16'h0002, 1'b1);
		close_out();
	end
endmodule // ptc_pattern_control_tb_top

`default_nettype wire
